// ===== src/mqx_defs.vh
// Constants for the multi-queue expansion and configuration block.
`ifndef MQX_DEFS_VH
`define MQX_DEFS_VH

`define MQX_ADDR_W          8
`define MQX_DEV_MSB         7
`define MQX_DEV_LSB         5
`define MQX_QUEUE_MSB       4
`define MQX_QUEUE_LSB       0
`define MQX_SECTOR_BIT      3

`define MQX_REG_CONTROL     8'h00
`define MQX_REG_STATUS      8'h04
`define MQX_REG_SELECT      8'h08

`define MQX_CTL_PROGRAMMED  0

`define MQX_ST_DEV_LSB      0
`define MQX_ST_IN_X9        3
`define MQX_ST_OUT_X9       4
`define MQX_ST_MASTER       5
`define MQX_ST_POLLED       6
`define MQX_ST_PROGRAMMED   7

`define MQX_SEL_WRQ_LSB     0
`define MQX_SEL_WR_VALID    5
`define MQX_SEL_RDQ_LSB     8
`define MQX_SEL_RD_OWNER    13
`define MQX_SEL_RD_VALID    14

`define MQX_RESP_OKAY       2'b00
`define MQX_RESP_DECERR     2'b11
`define MQX_DATA_ZERO       32'h0000_0000

`define MQX_PS_IDLE         2'b00
`define MQX_PS_SECTOR1      2'b01
`define MQX_PS_SECTOR2      2'b10

`endif

// ===== src/mqx_flag_poll.v
// Almost-full sector bus driver: polled token ring and direct sector selection.
`timescale 1ns/100ps
`include "mqx_defs.vh"

module mqx_flag_poll #(
   parameter SECTOR_W = 8
) (
   input  wire                    ref_clk,
   input  wire                    rst,
   input  wire                    poll_enable,
   input  wire                    poll_start,
   input  wire                    token_in,
   input  wire                    direct_enable,
   input  wire                    direct_select,
   input  wire                    direct_hit,
   input  wire                    direct_sector,
   input  wire [2*SECTOR_W-1:0]   flags_n,
   output reg  [SECTOR_W-1:0]     sector_bus,
   output reg                     sector_oe,
   output reg                     poll_sync,
   output reg                     token_out
);

   reg [1:0] state_reg;
   reg [1:0] state_next;

   always @* begin
      state_next = `MQX_PS_IDLE;
      if (poll_enable) begin
         case (state_reg)
            `MQX_PS_IDLE: begin
               if (token_in || poll_start) begin
                  state_next = `MQX_PS_SECTOR1;
               end
            end
            `MQX_PS_SECTOR1: begin
               state_next = `MQX_PS_SECTOR2;
            end
            `MQX_PS_SECTOR2: begin
               if (token_in) begin
                  state_next = `MQX_PS_SECTOR1;
               end
            end
            default: begin
               state_next = `MQX_PS_IDLE;
            end
         endcase
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         state_reg  <= `MQX_PS_IDLE;
         sector_bus <= {SECTOR_W{1'b1}};
         sector_oe  <= 1'b0;
         poll_sync  <= 1'b0;
         token_out  <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (poll_enable) begin
            poll_sync <= (state_next == `MQX_PS_SECTOR1);
            token_out <= (state_next == `MQX_PS_SECTOR2);
            sector_oe <= (state_next != `MQX_PS_IDLE);
            if (state_next == `MQX_PS_SECTOR2) begin
               sector_bus <= flags_n[2*SECTOR_W-1:SECTOR_W];
            end else begin
               sector_bus <= flags_n[SECTOR_W-1:0];
            end
         end else begin
            poll_sync <= 1'b0;
            token_out <= 1'b0;
            if (!direct_enable) begin
               sector_oe <= 1'b0;
            end else if (direct_select) begin
               // A strobe aimed at another device releases the shared bus.
               sector_oe <= direct_hit;
            end
            if (direct_enable && direct_select && direct_hit) begin
               sector_bus <= direct_sector ? flags_n[2*SECTOR_W-1:SECTOR_W] : flags_n[SECTOR_W-1:0];
            end
         end
      end
   end

endmodule

// ===== src/mqx_expansion.v
// Top of the multi-queue configuration, address decode, expansion and read-output control block.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "mqx_defs.vh"

module mqx_expansion #(
   parameter QUEUES   = 16,
   parameter SECTOR_W = 8
) (
   input  wire                  ref_clk,
   input  wire                  rst,
   input  wire                  full_reset_n,
   input  wire [2:0]            device_number_pins,
   input  wire                  input_width_select,
   input  wire                  output_width_select,
   input  wire                  primary_device_select,
   input  wire                  flag_bus_polling_select,
   input  wire [7:0]            write_queue_address,
   input  wire                  write_address_enable,
   input  wire                  flag_strobe,
   input  wire [7:0]            read_queue_address,
   input  wire                  read_address_enable,
   input  wire                  output_drive_enable_n,
   input  wire                  read_queue_empty,
   input  wire [QUEUES-1:0]     queue_almost_full_n,
   input  wire                  flag_token_in,
   output wire                  flag_token_out,
   output wire [SECTOR_W-1:0]   almost_full_sector_bus,
   output wire                  almost_full_sector_oe,
   output wire                  almost_full_poll_sync,
   output reg                   read_data_oe,
   output reg                   read_valid_flag_n,
   output reg                   read_valid_flag_oe,
   output reg                   write_select_valid,
   output reg  [4:0]            write_queue_index,
   output reg                   read_select_valid,
   output reg  [4:0]            read_queue_index,
   output reg                   input_bus_x9,
   output reg                   output_bus_x9,
   input  wire [7:0]            s_axi_awaddr,
   input  wire [2:0]            s_axi_awprot,
   input  wire                  s_axi_awvalid,
   output reg                   s_axi_awready,
   input  wire [31:0]           s_axi_wdata,
   input  wire [3:0]            s_axi_wstrb,
   input  wire                  s_axi_wvalid,
   output reg                   s_axi_wready,
   output reg  [1:0]            s_axi_bresp,
   output reg                   s_axi_bvalid,
   input  wire                  s_axi_bready,
   input  wire [7:0]            s_axi_araddr,
   input  wire [2:0]            s_axi_arprot,
   input  wire                  s_axi_arvalid,
   output reg                   s_axi_arready,
   output reg  [31:0]           s_axi_rdata,
   output reg  [1:0]            s_axi_rresp,
   output reg                   s_axi_rvalid,
   input  wire                  s_axi_rready
);

   // Straps and state held by the device.
   reg  [2:0] device_number_reg;
   reg        master_reg;
   reg        polled_reg;
   reg        programmed_reg;
   reg        in_reset_reg;
   reg        kick_pending_reg;
   reg        rd_owner_reg;
   reg        ov_stage1_reg;
   reg        ov_owner_stage1_reg;

   // Register bus holding state.
   reg        aw_held_reg;
   reg        w_held_reg;
   reg  [7:0] aw_addr_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0] w_strb_reg;

   wire       mr_active;
   wire       released;
   wire       wr_hit;
   wire       rd_hit;
   wire       wr_take;
   wire       rd_take;
   wire       poll_enable;
   wire       poll_start;
   wire       ctl_write;
   wire [31:0] status_word;
   wire [31:0] select_word;

   assign mr_active = ~full_reset_n;
   assign released  = in_reset_reg & full_reset_n;

   // Device field compared with the latched number; queue field picks a local queue.
   assign wr_hit  = (write_queue_address[`MQX_DEV_MSB:`MQX_DEV_LSB] == device_number_reg);
   assign rd_hit  = (read_queue_address[`MQX_DEV_MSB:`MQX_DEV_LSB] == device_number_reg);
   assign wr_take = write_address_enable & programmed_reg & ~mr_active;
   assign rd_take = read_address_enable & programmed_reg & ~mr_active;

   assign poll_enable = polled_reg & programmed_reg & ~mr_active;
   assign poll_start  = kick_pending_reg & poll_enable & master_reg;

   // Strap capture and master reset sequencing.
   always @(posedge ref_clk) begin
      if (rst) begin
         device_number_reg <= 3'h0;
         input_bus_x9      <= 1'b0;
         output_bus_x9     <= 1'b0;
         master_reg        <= 1'b0;
         polled_reg        <= 1'b0;
         in_reset_reg      <= 1'b0;
         kick_pending_reg  <= 1'b0;
      end else begin
         in_reset_reg <= mr_active;
         if (mr_active) begin
            device_number_reg <= device_number_pins;
            input_bus_x9      <= input_width_select;
            output_bus_x9     <= output_width_select;
            master_reg        <= primary_device_select;
            polled_reg        <= flag_bus_polling_select;
            kick_pending_reg  <= 1'b0;
         end else if (released) begin
            kick_pending_reg  <= master_reg;
         end else if (poll_start) begin
            kick_pending_reg  <= 1'b0;
         end
      end
   end

   // Queue selection on both ports, and ownership of the shared read outputs.
   always @(posedge ref_clk) begin
      if (rst) begin
         write_select_valid <= 1'b0;
         write_queue_index  <= 5'h00;
         read_select_valid  <= 1'b0;
         read_queue_index   <= 5'h00;
         rd_owner_reg       <= 1'b0;
      end else if (mr_active) begin
         write_select_valid <= 1'b0;
         read_select_valid  <= 1'b0;
         rd_owner_reg       <= 1'b0;
      end else begin
         if (released) begin
            rd_owner_reg <= master_reg;
         end
         if (wr_take) begin
            write_select_valid <= wr_hit;
            if (wr_hit) begin
               write_queue_index <= write_queue_address[`MQX_QUEUE_MSB:`MQX_QUEUE_LSB];
            end
         end
         if (rd_take) begin
            read_select_valid <= rd_hit;
            rd_owner_reg      <= rd_hit;
            if (rd_hit) begin
               read_queue_index <= read_queue_address[`MQX_QUEUE_MSB:`MQX_QUEUE_LSB];
            end
         end
      end
   end

   // Read data drive enable and the two-stage valid flag path.
   always @(posedge ref_clk) begin
      if (rst) begin
         read_data_oe        <= 1'b0;
         ov_stage1_reg       <= 1'b1;
         ov_owner_stage1_reg <= 1'b0;
         read_valid_flag_n   <= 1'b1;
         read_valid_flag_oe  <= 1'b0;
      end else begin
         read_data_oe <= rd_owner_reg & ~output_drive_enable_n & ~mr_active;
         if (rd_take && rd_hit) begin
            ov_stage1_reg <= 1'b1;
         end else begin
            ov_stage1_reg <= read_queue_empty;
         end
         ov_owner_stage1_reg <= rd_owner_reg & ~mr_active;
         read_valid_flag_n   <= ov_stage1_reg;
         read_valid_flag_oe  <= ov_owner_stage1_reg & ~mr_active;
      end
   end

   mqx_flag_poll #(
      .SECTOR_W (SECTOR_W)
   ) u_flag_poll (
      .ref_clk       (ref_clk),
      .rst           (rst | mr_active),
      .poll_enable   (poll_enable),
      .poll_start    (poll_start),
      .token_in      (flag_token_in),
      .direct_enable (~polled_reg & programmed_reg & ~mr_active),
      .direct_select (flag_strobe & write_address_enable),
      .direct_hit    (wr_hit),
      .direct_sector (write_queue_address[`MQX_SECTOR_BIT]),
      .flags_n       (queue_almost_full_n[2*SECTOR_W-1:0]),
      .sector_bus    (almost_full_sector_bus),
      .sector_oe     (almost_full_sector_oe),
      .poll_sync     (almost_full_poll_sync),
      .token_out     (flag_token_out)
   );

   // Register bus: write address and data are taken in either order.
   assign ctl_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;

   always @(posedge ref_clk) begin
      if (rst) begin
         aw_held_reg    <= 1'b0;
         w_held_reg     <= 1'b0;
         aw_addr_reg    <= 8'h00;
         w_data_reg     <= `MQX_DATA_ZERO;
         w_strb_reg     <= 4'h0;
         s_axi_awready  <= 1'b1;
         s_axi_wready   <= 1'b1;
         s_axi_bvalid   <= 1'b0;
         s_axi_bresp    <= `MQX_RESP_OKAY;
         programmed_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg   <= 1'b1;
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (ctl_write) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr_reg)
               `MQX_REG_CONTROL, `MQX_REG_STATUS, `MQX_REG_SELECT: begin
                  s_axi_bresp <= `MQX_RESP_OKAY;
               end
               default: begin
                  s_axi_bresp <= `MQX_RESP_DECERR;
               end
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         // Programming is lost with every master reset and must be redone.
         if (mr_active) begin
            programmed_reg <= 1'b0;
         end else if (ctl_write && aw_addr_reg == `MQX_REG_CONTROL && w_strb_reg[0]) begin
            programmed_reg <= w_data_reg[`MQX_CTL_PROGRAMMED];
         end
      end
   end

   assign status_word = {24'h00_0000, programmed_reg, polled_reg, master_reg, output_bus_x9,
                         input_bus_x9, device_number_reg};
   assign select_word = {17'h0_0000, read_select_valid, rd_owner_reg, read_queue_index,
                         2'b00, write_select_valid, write_queue_index};

   // Register bus: one read at a time, answered the cycle after it is taken.
   always @(posedge ref_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= `MQX_DATA_ZERO;
         s_axi_rresp   <= `MQX_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `MQX_RESP_OKAY;
            case (s_axi_araddr)
               `MQX_REG_CONTROL: begin
                  s_axi_rdata <= {31'h0000_0000, programmed_reg};
               end
               `MQX_REG_STATUS: begin
                  s_axi_rdata <= status_word;
               end
               `MQX_REG_SELECT: begin
                  s_axi_rdata <= select_word;
               end
               default: begin
                  s_axi_rdata <= `MQX_DATA_ZERO;
                  s_axi_rresp <= `MQX_RESP_DECERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// ===== test/mqx_expansion_asserts.sv
// Concurrent checks on the ports of the expansion block.
`timescale 1ns/100ps
`include "mqx_defs.vh"
module mqx_expansion_asserts (
   input wire        ref_clk,
   input wire        rst,
   input wire        full_reset_n,
   input wire [2:0]  device_number_pins,
   input wire        input_width_select,
   input wire        output_width_select,
   input wire        primary_device_select,
   input wire        flag_bus_polling_select,
   input wire [7:0]  write_queue_address,
   input wire        write_address_enable,
   input wire        flag_strobe,
   input wire [7:0]  read_queue_address,
   input wire        read_address_enable,
   input wire        output_drive_enable_n,
   input wire        read_queue_empty,
   input wire        flag_token_in,
   input wire        flag_token_out,
   input wire        almost_full_sector_oe,
   input wire        almost_full_poll_sync,
   input wire        read_data_oe,
   input wire        read_valid_flag_n,
   input wire        read_valid_flag_oe,
   input wire        write_select_valid,
   input wire        read_select_valid,
   input wire        input_bus_x9,
   input wire        output_bus_x9,
   input wire [7:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid
);
   reg [2:0] id_q, wdev_q, rdev_q;
   reg       iw_q, ow_q, mst_q, pol_q, prog_q, wen_q, fs_q, ren_q, fr_q, bv_q, wd_q;
   reg [7:0] aw_q;

   // The programmed state is tracked one edge late, so selections are only judged once it is surely set.
   always @(posedge ref_clk) begin
      wen_q  <= write_address_enable;
      fs_q   <= flag_strobe;
      ren_q  <= read_address_enable;
      wdev_q <= write_queue_address[7:5];
      rdev_q <= read_queue_address[7:5];
      fr_q   <= full_reset_n;
      bv_q   <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[0];
      if (rst || !full_reset_n) prog_q <= 1'b0;
      else if (s_axi_bvalid && !bv_q && aw_q == `MQX_REG_CONTROL) prog_q <= wd_q;
      if (rst) begin
         {id_q, iw_q, ow_q, mst_q, pol_q} <= 7'h00;
      end else if (!full_reset_n) begin
         {id_q, iw_q, ow_q, mst_q, pol_q} <= {device_number_pins, input_width_select, output_width_select,
                                              primary_device_select, flag_bus_polling_select};
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_wr_match: assert property (wen_q && !fs_q && prog_q && fr_q |-> write_select_valid == (wdev_q == id_q))
      else $error("write selection decode wrong");
   a_rd_match: assert property (ren_q && prog_q && fr_q |-> read_select_valid == (rdev_q == id_q))
      else $error("read selection decode wrong");
   a_valid_lag: assert property ($rose(read_select_valid) && !read_address_enable |-> ##1 read_valid_flag_n
      ##1 (read_valid_flag_oe && read_valid_flag_n == $past(read_queue_empty, 2)))
      else $error("valid flag timing wrong");
   a_oe_follow: assert property (full_reset_n && fr_q && read_select_valid && $past(read_select_valid)
      |-> read_data_oe == !$past(output_drive_enable_n))
      else $error("read drive enable wrong");
   a_slave_release: assert property ((!mst_q && !read_select_valid)[*3] |-> !read_data_oe && !read_valid_flag_oe)
      else $error("unselected slave drives");
   a_sync_pair: assert property (almost_full_poll_sync |-> almost_full_sector_oe
      ##1 (flag_token_out && almost_full_sector_oe && !almost_full_poll_sync))
      else $error("sector pair wrong");
   a_token_start: assert property (pol_q && prog_q && full_reset_n && flag_token_in && !almost_full_poll_sync
      |=> almost_full_poll_sync && almost_full_sector_oe)
      else $error("token did not load sector one");
   a_strap_hold: assert property (full_reset_n && fr_q |-> input_bus_x9 == iw_q && output_bus_x9 == ow_q)
      else $error("width strap wrong");

   c_hit: cover property (read_select_valid && read_data_oe);
   c_ring: cover property (flag_token_out ##1 !almost_full_sector_oe);
   c_direct: cover property (!pol_q && almost_full_sector_oe);
endmodule

// ===== test/mqx_ring_model.sv
// Token ring of chained devices seen from one device's token pins.
`timescale 1ns/100ps
module mqx_ring_model (
   input  wire       ref_clk,
   input  wire [1:0] ring_mode,
   input  wire       token_out,
   output logic      token_in
);
   logic [5:0] hop_reg = 6'h00;

   // Mode 2 stands for three further devices, each holding the token for two sectors.
   always @(posedge ref_clk) begin
      hop_reg <= (ring_mode == 2'h2) ? {hop_reg[4:0], token_out} : 6'h00;
   end

   always @* begin
      case (ring_mode)
         2'h1:    token_in = token_out;
         2'h2:    token_in = hop_reg[5];
         default: token_in = 1'b0;
      endcase
   end
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the multi-queue expansion block.
`timescale 1ns/100ps
`include "mqx_defs.vh"
module tb_top;
   logic        ref_clk, rst, full_reset_n, input_width_select, output_width_select;
   logic        primary_device_select, flag_bus_polling_select, write_address_enable, flag_strobe;
   logic        read_address_enable, output_drive_enable_n, read_queue_empty;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [2:0]  device_number_pins;
   logic [7:0]  write_queue_address, read_queue_address, s_axi_awaddr, s_axi_araddr;
   logic [15:0] queue_almost_full_n;
   logic [31:0] s_axi_wdata, rd_data;
   logic [1:0]  ring_mode, rd_resp;
   wire         flag_token_in, flag_token_out, almost_full_sector_oe, almost_full_poll_sync;
   wire         read_data_oe, read_valid_flag_n, read_valid_flag_oe, write_select_valid;
   wire         read_select_valid, input_bus_x9, output_bus_x9, s_axi_awready, s_axi_wready;
   wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [7:0]   almost_full_sector_bus;
   wire [4:0]   write_queue_index, read_queue_index;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   integer      err_count = 0;
   integer      samples_checked = 0;

   mqx_expansion u_dut (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hf));
   mqx_ring_model u_ring (.ref_clk, .ring_mode, .token_out(flag_token_out), .token_in(flag_token_in));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task chk(input string nm, input [33:0] e, input [33:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task step(input integer n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic axi_wr(input [7:0] a, input [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      rd_resp = s_axi_bresp;
   endtask

   task automatic axi_rd(input [7:0] a);
      @(posedge ref_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
   endtask

   task rsel(input [7:0] a);
      @(posedge ref_clk);
      read_queue_address  <= a;
      read_address_enable <= 1'b1;
      @(posedge ref_clk);
      read_address_enable <= 1'b0;
      #1;
   endtask

   task wsel(input [7:0] a, input s);
      @(posedge ref_clk);
      write_queue_address  <= a;
      write_address_enable <= 1'b1;
      flag_strobe          <= s;
      @(posedge ref_clk);
      write_address_enable <= 1'b0;
      flag_strobe          <= 1'b0;
      #1;
   endtask

   task automatic wait_on(input bit tok);
      integer n = 0;
      do begin
         step(1);
         n++;
      end while ((tok ? flag_token_out : almost_full_poll_sync) !== 1'b1 && n < 20);
      chk("wait_on", 1'b1, tok ? flag_token_out : almost_full_poll_sync);
   endtask

   task automatic mrst(input [2:0] id, input mst, input pol, input iw, input ow);
      @(posedge ref_clk);
      full_reset_n            <= 1'b0;
      device_number_pins      <= id;
      primary_device_select   <= mst;
      flag_bus_polling_select <= pol;
      input_width_select      <= iw;
      output_width_select     <= ow;
      repeat (3) @(posedge ref_clk);
      full_reset_n <= 1'b1;
      step(3);
      chk("owner", mst, read_data_oe);
      chk("width_in", iw, input_bus_x9);
      chk("width_out", ow, output_bus_x9);
      axi_rd(`MQX_REG_STATUS);
      chk("status", {pol, mst, ow, iw, id}, rd_data);
      rsel({id, 5'h02});
      chk("unprogrammed", 1'b0, read_select_valid);
      axi_wr(`MQX_REG_CONTROL, 32'h0000_0001);
      chk("bresp", `MQX_RESP_OKAY, rd_resp);
      axi_rd(`MQX_REG_STATUS);
      chk("programmed", 1'b1, rd_data[`MQX_ST_PROGRAMMED]);
   endtask

   task t_select;
      mrst(3'h5, 1'b0, 1'b0, 1'b1, 1'b0);
      rsel(8'h63);
      step(3);
      chk("rd_oe_miss", 1'b0, read_data_oe);
      chk("ov_oe_miss", 1'b0, read_valid_flag_oe);
      rsel(8'hA9);
      chk("rd_hit", 6'h29, {read_select_valid, read_queue_index});
      step(1);
      chk("rd_oe_hit", 1'b1, read_data_oe);
      chk("ov_first", 1'b1, read_valid_flag_n);
      step(1);
      chk("ov_valid", 2'h2, {read_valid_flag_oe, read_valid_flag_n});
      @(posedge ref_clk);
      read_queue_empty      <= 1'b1;
      output_drive_enable_n <= 1'b1;
      step(3);
      chk("ov_empty", 1'b1, read_valid_flag_n);
      chk("rd_oe_off", 1'b0, read_data_oe);
      @(posedge ref_clk);
      read_queue_empty      <= 1'b0;
      output_drive_enable_n <= 1'b0;
      wsel(8'hBF, 1'b0);
      chk("wr_hit", 6'h3F, {write_select_valid, write_queue_index});
      axi_rd(`MQX_REG_SELECT);
      chk("select", 32'h0000_693F, rd_data);
      wsel(8'hE0, 1'b0);
      chk("wr_miss", 1'b0, write_select_valid);
      wsel(8'hA8, 1'b1);
      chk("direct_hit", 9'h1A5, {almost_full_sector_oe, almost_full_sector_bus});
      wsel(8'hA0, 1'b1);
      chk("direct_low", 9'h13C, {almost_full_sector_oe, almost_full_sector_bus});
      wsel(8'h48, 1'b1);
      chk("direct_miss", 1'b0, almost_full_sector_oe);
      axi_rd(8'h0C);
      chk("unmapped", 34'h3_0000_0000, {rd_resp, rd_data});
      axi_wr(8'h0C, 32'h0000_0000);
      chk("wr_unmapped", `MQX_RESP_DECERR, rd_resp);
      $display("test select done");
   endtask

   task t_poll;
      @(posedge ref_clk);
      ring_mode <= 2'h1;
      mrst(3'h0, 1'b1, 1'b1, 1'b0, 1'b1);
      wait_on(1'b0);
      chk("sector1", 10'h33C, {almost_full_poll_sync, almost_full_sector_oe, almost_full_sector_bus});
      step(1);
      chk("sector2", 11'h5A5, {flag_token_out, almost_full_poll_sync, almost_full_sector_oe,
                               almost_full_sector_bus});
      step(1);
      chk("loop", 1'b1, almost_full_poll_sync);
      @(posedge ref_clk);
      ring_mode <= 2'h2;
      wait_on(1'b1);
      step(1);
      chk("released", 1'b0, almost_full_sector_oe);
      wait_on(1'b0);
      chk("chain_back", 1'b1, almost_full_sector_oe);
      $display("test poll done");
   endtask

   initial begin
      rst                 = 1'b1;
      full_reset_n        = 1'b1;
      queue_almost_full_n = 16'hA53C;
      {input_width_select, output_width_select, primary_device_select, flag_bus_polling_select,
       write_address_enable, flag_strobe, read_address_enable, output_drive_enable_n, read_queue_empty,
       s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, device_number_pins,
       write_queue_address, read_queue_address, s_axi_awaddr, s_axi_araddr, s_axi_wdata, ring_mode} = '0;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      t_select;
      t_poll;
      end_sim;
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      err_count++;
      end_sim;
   end
endmodule

bind mqx_expansion mqx_expansion_asserts u_chk (.*);
